// [rtl/sleep_state_power_sequencer.sv]
`timescale 1ns/1ps
// Sleep-state and reset sequencer driving sleep, suspend, bus reset and processor control outputs.
//
// What this block does
// - Sleep outputs and bus reset asserted within 50 ns of standby supply good.
// - S3 sleep output released 1 to 4 RTC clocks after resume reset release.
// - S5 sleep output released 1 to 4 RTC clocks after resume reset release.
// - Suspend status released 1 to 4 RTC clocks after resume reset release.
// - Processor sleep released within 50 ns of core supply good.
// - Bus reset held at least 500 us after clocks become valid.
// - Bus reset released 0.9 to 1.1 ms after core power good.
// - Stop-clock released 1 to 4 PCI clocks after bus reset release.
// - Frequency straps valid from 4 PCI clocks before to 4 after bus reset edge.
// - Straps stop being driven within 180 ns after second post-reset cycle.
// - Processor reset released within 110 ns after second post-reset cycle.
// - Processor sleep asserted within 8 PCI clocks of a stop-grant cycle with a sleep or soft-off request.
// - Suspend status asserted within 1 RTC clock after processor sleep.
// - Bus reset asserted 2 to 3 RTC clocks after suspend status in sleep entry.
// - S3 sleep asserted 1 to 2 RTC clocks after bus reset in sleep entry.
// - S3 sleep released 2 to 3 RTC clocks after a wake event.
// - S5 sleep asserted 1 to 2 RTC clocks after S3 sleep on soft-off entry.
// - S3 sleep released 2 to 3 RTC clocks after S5 sleep on soft-off exit.
// - Resume reset and core power good each drive a well isolation enable.
module sleep_state_power_sequencer
  import sleep_seq_pkg::*;
#(
  parameter int unsigned CORE_POWER_GOOD_RESET_CYCLES = sleep_seq_pkg::CORE_POWER_GOOD_RESET_CYC,
  parameter int unsigned CLOCKS_VALID_CYCLES = sleep_seq_pkg::CLOCKS_VALID_CYC,
  parameter int unsigned STRAP_W            = 4
)
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Slow clocks, sampled as levels
  input  wire logic               rtc_clk,
  input  wire logic               pci_clk,
  // Board power inputs
  input  wire logic               resume_well_reset_n,
  input  wire logic               core_power_good,
  input  wire logic               clocks_valid,
  // Processor and bus events
  input  wire logic               stop_grant,
  input  wire logic               second_cycle,
  input  wire logic               sleep_request,
  input  wire logic               soft_off_request,
  input  wire logic               wake_event,
  input  wire logic [STRAP_W-1:0] strap_value,
  // Sleep and reset outputs
  output logic                    sleep_state3_n,
  output logic                    sleep_state5_n,
  output logic                    suspend_status_n,
  output logic                    pci_bus_reset_n,
  output logic                    processor_sleep_n,
  output logic                    stop_clock_n,
  output logic                    processor_reset_n,
  // Frequency straps toward processor
  output logic [STRAP_W-1:0]      strap_out,
  output logic [STRAP_W-1:0]      strap_oe,
  // Well isolation enables
  output logic                    rtc_resume_isolate,
  output logic                    resume_main_isolate
);
  import sleep_seq_pkg::*;

  initial
  begin
    if (CORE_POWER_GOOD_RESET_CYCLES < 2 || CORE_POWER_GOOD_RESET_CYCLES >= (1 << CNT_W))
      $error("CORE_POWER_GOOD_RESET_CYCLES out of range");
    if (CLOCKS_VALID_CYCLES < 1 || CLOCKS_VALID_CYCLES >= (1 << CNT_W))
      $error("CLOCKS_VALID_CYCLES out of range");
    if (STRAP_W < 1)
      $error("STRAP_W must be positive");
  end

  typedef struct packed {
    seq_state_t         state;
    logic [CNT_W-1:0]   pwr_cnt;
    logic [CNT_W-1:0]   clk_cnt;
    logic [TICK_W-1:0]  ticks;
    logic [7:0]         fast_cnt;
    logic               s3_n;
    logic               s5_n;
    logic               sus_n;
    logic               bus_rst_n;
    logic               cpu_slp_n;
    logic               stop_clock_n_n;
    logic               cpu_rst_n;
    logic               strap_en;
    logic [STRAP_W-1:0] strap;
    logic               to_soft_off;
  } seq_regs_t;

  localparam seq_regs_t REGS_RESET = '{
    state: ST_RESUME_RST, pwr_cnt: '0, clk_cnt: '0, ticks: '0, fast_cnt: '0,
    s3_n: 1'b0, s5_n: 1'b0, sus_n: 1'b0, bus_rst_n: 1'b0, cpu_slp_n: 1'b0,
    stop_clock_n_n: 1'b0, cpu_rst_n: 1'b0, strap_en: 1'b0, strap: '0, to_soft_off: 1'b0
  };

  localparam logic [CNT_W-1:0] PWR_LAST = CNT_W'(CORE_POWER_GOOD_RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLK_LAST = CNT_W'(CLOCKS_VALID_CYCLES - 1);

  seq_regs_t seq_r;
  seq_regs_t seq_nxt;
  logic      rtc_tick;
  logic      pci_tick;
  logic      clk_done;

  tick_edge u_rtc_tick (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .slow_clk (rtc_clk),
    .tick     (rtc_tick)
  );

  tick_edge u_pci_tick (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .slow_clk (pci_clk),
    .tick     (pci_tick)
  );

  assign clk_done = (seq_r.clk_cnt == CLK_LAST);

  always_comb
  begin
    seq_nxt = seq_r;
    // Clocks-valid time is counted independently so both bus reset minimums hold.
    if (!clocks_valid)
      seq_nxt.clk_cnt = '0;
    else if (!clk_done)
      seq_nxt.clk_cnt = seq_r.clk_cnt + CNT_W'(1);
    case (seq_r.state)
      ST_RESUME_RST:
      begin
        seq_nxt       = REGS_RESET;
        seq_nxt.state = ST_RSM_WAIT;
      end
      ST_RSM_WAIT:
      begin
        if (rtc_tick)
        begin
          seq_nxt.ticks = seq_r.ticks + TICK_W'(1);
          if (seq_r.ticks == TICK_W'(RSM_RELEASE_TICKS - 1))
          begin
            seq_nxt.s3_n  = 1'b1;
            seq_nxt.s5_n  = 1'b1;
            seq_nxt.sus_n = 1'b1;
            seq_nxt.ticks = '0;
            seq_nxt.state = ST_CORE_WAIT;
          end
        end
      end
      ST_CORE_WAIT:
      begin
        seq_nxt.pwr_cnt = '0;
        if (core_power_good)
        begin
          seq_nxt.cpu_slp_n = 1'b1;
          seq_nxt.state     = ST_BUS_RESET;
        end
      end
      ST_BUS_RESET:
      begin
        seq_nxt.pwr_cnt = seq_r.pwr_cnt + CNT_W'(1);
        // Straps are put out a few PCI clocks ahead of the bus reset edge.
        if (seq_r.pwr_cnt >= PWR_LAST - CNT_W'(STRAP_LEAD_TICKS * 4 * REF_CLK_MHZ / 33))
        begin
          seq_nxt.strap_en = 1'b1;
          seq_nxt.strap    = strap_value;
        end
        if (seq_r.pwr_cnt >= PWR_LAST && clk_done)
        begin
          seq_nxt.bus_rst_n = 1'b1;
          seq_nxt.ticks     = '0;
          seq_nxt.state     = ST_STOP_CLOCK_N;
        end
      end
      ST_STOP_CLOCK_N:
      begin
        if (pci_tick)
        begin
          seq_nxt.ticks = seq_r.ticks + TICK_W'(1);
          if (seq_r.ticks == TICK_W'(STOP_CLOCK_N_TICKS - 1))
          begin
            seq_nxt.stop_clock_n_n = 1'b1;
            seq_nxt.state    = ST_STRAP;
          end
        end
      end
      ST_STRAP:
      begin
        seq_nxt.fast_cnt = '0;
        if (second_cycle)
        begin
          seq_nxt.cpu_rst_n = 1'b1;
          seq_nxt.strap_en  = 1'b0;
          seq_nxt.state     = ST_RUN;
        end
      end
      ST_RUN:
      begin
        seq_nxt.ticks = '0;
        if (stop_grant && (sleep_request || soft_off_request))
        begin
          seq_nxt.cpu_slp_n   = 1'b0;
          seq_nxt.to_soft_off = soft_off_request;
          seq_nxt.state       = ST_SLP_SUS;
        end
      end
      ST_SLP_SUS:
      begin
        if (rtc_tick)
        begin
          seq_nxt.sus_n = 1'b0;
          seq_nxt.ticks = '0;
          seq_nxt.state = ST_SLP_BUS;
        end
      end
      ST_SLP_BUS:
      begin
        if (rtc_tick)
        begin
          seq_nxt.ticks = seq_r.ticks + TICK_W'(1);
          if (seq_r.ticks == TICK_W'(SUS_TO_RESET_TICKS - 1))
          begin
            seq_nxt.bus_rst_n = 1'b0;
            seq_nxt.stop_clock_n_n  = 1'b0;
            seq_nxt.cpu_rst_n = 1'b0;
            seq_nxt.ticks     = '0;
            seq_nxt.state     = ST_SLEEP_STATE3_N;
          end
        end
      end
      ST_SLEEP_STATE3_N:
      begin
        if (rtc_tick)
        begin
          seq_nxt.ticks = seq_r.ticks + TICK_W'(1);
          if (seq_r.ticks == TICK_W'(RESET_TO_S3_TICKS - 1))
          begin
            seq_nxt.s3_n  = 1'b0;
            seq_nxt.ticks = '0;
            seq_nxt.state = seq_r.to_soft_off ? ST_SLEEP_STATE5_N : ST_SUSPENDED;
          end
        end
      end
      ST_SLEEP_STATE5_N:
      begin
        if (rtc_tick)
        begin
          seq_nxt.s5_n  = 1'b0;
          seq_nxt.ticks = '0;
          seq_nxt.state = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED:
      begin
        // A wake is taken on any cycle in this state without waiting for a tick; a wake before this state is reached is not held and is lost.
        if (wake_event)
        begin
          seq_nxt.ticks = '0;
          seq_nxt.state = seq_r.s5_n ? ST_WAKE_S3 : ST_WAKE_S5;
        end
      end
      ST_WAKE_S5:
      begin
        if (rtc_tick)
        begin
          seq_nxt.s5_n  = 1'b1;
          seq_nxt.state = ST_WAKE_S3;
        end
      end
      ST_WAKE_S3:
      begin
        if (rtc_tick)
        begin
          seq_nxt.ticks = seq_r.ticks + TICK_W'(1);
          if (seq_r.ticks == TICK_W'(WAKE_TO_S3_TICKS - 1))
          begin
            seq_nxt.s3_n  = 1'b1;
            seq_nxt.sus_n = 1'b1;
            seq_nxt.ticks = '0;
            seq_nxt.state = ST_CORE_WAIT;
          end
        end
      end
      default:
        seq_nxt = REGS_RESET;
    endcase
    // Losing core power in bus reset, stop-clock or strap drops back to waiting with the bus held in reset.
    if (!core_power_good && seq_r.state inside {ST_BUS_RESET, ST_STOP_CLOCK_N, ST_STRAP})
    begin
      seq_nxt.state     = ST_CORE_WAIT;
      seq_nxt.bus_rst_n = 1'b0;
      seq_nxt.strap_en  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !resume_well_reset_n)
      seq_r <= REGS_RESET;
    else
      seq_r <= seq_nxt;
  end

  // S3 sleep, S5 sleep and bus reset are gated directly by the resume reset so they act within one path delay.
  assign sleep_state3_n      = seq_r.s3_n & resume_well_reset_n;
  assign sleep_state5_n      = seq_r.s5_n & resume_well_reset_n;
  assign pci_bus_reset_n     = seq_r.bus_rst_n & resume_well_reset_n & core_power_good;
  assign suspend_status_n    = seq_r.sus_n;
  // Processor sleep is gated by core power directly, so a supply loss acts within one path delay.
  assign processor_sleep_n   = core_power_good & seq_r.cpu_slp_n;
  assign stop_clock_n        = seq_r.stop_clock_n_n;
  assign processor_reset_n   = seq_r.cpu_rst_n;
  assign strap_out           = seq_r.strap;
  assign strap_oe            = {STRAP_W{seq_r.strap_en}};
  assign rtc_resume_isolate  = ~resume_well_reset_n;
  assign resume_main_isolate = ~core_power_good;

endmodule : sleep_state_power_sequencer

// [common/sleep_seq_pkg.sv]
// Package holding timing counts and state codes for the sleep-state power sequencer.
package sleep_seq_pkg;

  // Reference clock rate.
  localparam int unsigned REF_CLK_MHZ          = 100;
  localparam int unsigned REF_CLK_PERIOD_NS    = 1000 / REF_CLK_MHZ;

  // Asynchronous-response limits in nanoseconds.
  localparam int unsigned STANDBY_ASSERT_MAX_NS = 50;
  localparam int unsigned CORE_SLEEP_MAX_NS     = 50;
  localparam int unsigned STRAP_RELEASE_MAX_NS  = 180;
  localparam int unsigned CPU_RESET_MAX_NS      = 110;
  localparam int unsigned STRAP_RELEASE_CYC     = STRAP_RELEASE_MAX_NS / REF_CLK_PERIOD_NS;
  localparam int unsigned CPU_RESET_CYC         = CPU_RESET_MAX_NS / REF_CLK_PERIOD_NS;

  // Bus reset timing in microseconds; 0.9 ms to 1.1 ms window, aim at 1.0 ms.
  localparam int unsigned CLOCKS_VALID_MIN_US  = 500;
  localparam int unsigned CORE_POWER_GOOD_RESET_MIN_US   = 900;
  localparam int unsigned CORE_POWER_GOOD_RESET_MAX_US   = 1100;
  localparam int unsigned CORE_POWER_GOOD_RESET_NOM_US   = 1000;
  localparam int unsigned CORE_POWER_GOOD_RESET_CYC      = CORE_POWER_GOOD_RESET_NOM_US * REF_CLK_MHZ;
  localparam int unsigned CLOCKS_VALID_CYC     = CLOCKS_VALID_MIN_US * REF_CLK_MHZ;

  // Counts in slow-clock ticks (real-time clock or PCI clock).
  localparam int unsigned RSM_RELEASE_TICKS    = 2;
  localparam int unsigned STOP_CLOCK_N_TICKS         = 2;
  localparam int unsigned STRAP_LEAD_TICKS     = 2;
  localparam int unsigned SLEEP_ACK_TICKS      = 4;
  localparam int unsigned SUS_TO_RESET_TICKS   = 2;
  localparam int unsigned RESET_TO_S3_TICKS    = 1;
  localparam int unsigned WAKE_TO_S3_TICKS     = 2;
  localparam int unsigned S3_TO_S5_TICKS       = 1;
  localparam int unsigned S5_TO_S3_TICKS       = 2;

  localparam int unsigned TICK_W               = 4;
  localparam int unsigned CNT_W                = 24;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_RESUME_RST = 4'h0,
    ST_RSM_WAIT   = 4'h1,
    ST_SUSPENDED  = 4'h2,
    ST_CORE_WAIT  = 4'h3,
    ST_BUS_RESET  = 4'h4,
    ST_STOP_CLOCK_N     = 4'h5,
    ST_STRAP      = 4'h6,
    ST_RUN        = 4'h7,
    ST_SLP_SUS    = 4'h8,
    ST_SLP_BUS    = 4'h9,
    ST_SLEEP_STATE3_N     = 4'hA,
    ST_SLEEP_STATE5_N     = 4'hB,
    ST_WAKE_S5    = 4'hC,
    ST_WAKE_S3    = 4'hD
  } seq_state_t;

endpackage : sleep_seq_pkg

// [rtl/tick_edge.sv]
`timescale 1ns/1ps
// Rising-edge detector turning a slow clock level into a one-cycle tick.
module tick_edge (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Slow clock level and tick
  input  wire logic slow_clk,
  output logic      tick
);

  typedef struct packed {
    logic last;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.last = slow_clk;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // The slow clocks are taken as synchronous, so no extra synchroniser is spent here.
  assign tick = slow_clk & ~st_r.last;

endmodule : tick_edge

// [verif/sleep_seq_asserts.sv]
// Checker holding timing and ordering assertions on the sleep sequencer ports.
`timescale 1ns/1ps
module sleep_seq_asserts #(
  parameter int unsigned CORE_POWER_GOOD_RESET_CYCLES = 50
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Slow clocks and board inputs
  input wire logic rtc_clk,
  input wire logic pci_clk,
  input wire logic resume_well_reset_n,
  input wire logic core_power_good,
  input wire logic stop_grant,
  input wire logic sleep_request,
  // Sequencer outputs
  input wire logic sleep_state3_n,
  input wire logic sleep_state5_n,
  input wire logic suspend_status_n,
  input wire logic pci_bus_reset_n,
  input wire logic processor_sleep_n,
  input wire logic stop_clock_n,
  input wire logic processor_reset_n,
  input wire logic rtc_resume_isolate,
  input wire logic resume_main_isolate
);
  localparam int PW_LO = int'(CORE_POWER_GOOD_RESET_CYCLES * 9 / 10);
  localparam int PW_HI = int'(CORE_POWER_GOOD_RESET_CYCLES * 11 / 10);
  logic [4:0]  seen_r;
  logic        rtc_r;
  logic        pci_r;
  logic        booted_r;
  logic [3:0]  rt_r;
  logic [3:0]  pt_r;
  logic [15:0] pg_r;
  wire logic [4:0] seen = {resume_well_reset_n, sleep_state3_n, sleep_state5_n, suspend_status_n, pci_bus_reset_n};
  wire logic       rtc_t = rtc_clk & ~rtc_r;
  wire logic       pci_t = pci_clk & ~pci_r;

  // Ticks are counted since the last output change, so windows are judged in slow-clock periods.
  always_ff @(posedge ref_clk)
  begin
    rtc_r <= rtc_clk;
    pci_r <= pci_clk;
    seen_r <= seen;
    booted_r <= (rst || !resume_well_reset_n) ? 1'b0 : (booted_r | (sleep_state3_n & suspend_status_n));
    rt_r <= (rst || seen != seen_r) ? 4'h0 : rt_r + {3'h0, rtc_t && rt_r != 4'hF};
    pt_r <= (rst || !pci_bus_reset_n) ? 4'h0 : pt_r + {3'h0, pci_t && pt_r != 4'hF};
    pg_r <= (rst || !core_power_good) ? 16'h0 : pg_r + {15'h0, pg_r != 16'hFFFF};
  end

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property boot_rel(logic sig);
    !booted_r && $rose(sig) |-> rt_r inside {[4'h1:4'h4]};
  endproperty

  hold_reset_a: assert property (!resume_well_reset_n |-> !sleep_state3_n && !sleep_state5_n && !pci_bus_reset_n)
    else $error("outputs released during resume reset");
  well_iso_a: assert property (rtc_resume_isolate == !resume_well_reset_n && resume_main_isolate == !core_power_good)
    else $error("isolation enables wrong");
  boot_s3_a: assert property (boot_rel(sleep_state3_n))
    else $error("s3 release window");
  boot_s5_a: assert property (boot_rel(sleep_state5_n))
    else $error("s5 release window");
  boot_sus_a: assert property (boot_rel(suspend_status_n))
    else $error("suspend release window");
  bus_release_a: assert property ($rose(pci_bus_reset_n) |-> pg_r >= PW_LO && pg_r <= PW_HI)
    else $error("bus reset release window");
  stop_clock_a: assert property ($rose(stop_clock_n) |-> pt_r inside {[4'h1:4'h4]})
    else $error("stop clock release window");
  grant_sleep_a: assert property (stop_grant && sleep_request && processor_reset_n && processor_sleep_n
    |-> ##[0:32] !processor_sleep_n) else $error("processor sleep late");
  sus_follow_a: assert property ($fell(processor_sleep_n) && core_power_good && resume_well_reset_n
    |-> ##[0:12] !suspend_status_n) else $error("suspend entry late");
  bus_after_sus_a: assert property ($fell(pci_bus_reset_n) && core_power_good && resume_well_reset_n
    |-> rt_r inside {[4'h2:4'h3]}) else $error("bus reset entry window");
  s3_after_bus_a: assert property ($fell(sleep_state3_n) && resume_well_reset_n |-> rt_r inside {[4'h1:4'h2]})
    else $error("s3 entry window");
  s5_after_s3_a: assert property ($fell(sleep_state5_n) && resume_well_reset_n |-> rt_r inside {[4'h1:4'h2]})
    else $error("s5 entry window");

  cover property ($fell(sleep_state5_n));
  cover property ($rose(pci_bus_reset_n));
  cover property ($fell(processor_sleep_n));
endmodule : sleep_seq_asserts

bind sleep_state_power_sequencer sleep_seq_asserts #(.CORE_POWER_GOOD_RESET_CYCLES(CORE_POWER_GOOD_RESET_CYCLES)) chk_u (
  .ref_clk, .rst, .rtc_clk, .pci_clk, .resume_well_reset_n, .core_power_good, .stop_grant, .sleep_request,
  .sleep_state3_n, .sleep_state5_n, .suspend_status_n, .pci_bus_reset_n, .processor_sleep_n, .stop_clock_n,
  .processor_reset_n, .rtc_resume_isolate, .resume_main_isolate);

// [verif/board_power_model.sv]
// Board model making slow clocks, resume reset and core power good for the sequencer.
`timescale 1ns/1ps
module board_power_model #(
  parameter int RSM_DLY  = 30,
  parameter int CORE_DLY = 40
)(
  // Clock and commands
  input wire logic ref_clk,
  input wire logic standby_on,
  input wire logic sleep_state3_n,
  // Board outputs
  output logic     rtc_clk,
  output logic     pci_clk,
  output logic     resume_well_reset_n,
  output logic     core_power_good,
  output logic     clocks_valid
);
  logic [2:0] div = 3'h0;
  int         rsm_c = 0;
  int         core_c = 0;

  initial
  begin
    rtc_clk = 1'b0;
    pci_clk = 1'b0;
    resume_well_reset_n = 1'b0;
    core_power_good = 1'b0;
    clocks_valid = 1'b0;
  end

  // Delays are scaled far down from the board's real milliseconds to keep runs short.
  always @(negedge ref_clk)
  begin
    div <= div + 3'h1;
    rtc_clk <= div[2];
    pci_clk <= div[1];
    rsm_c <= standby_on ? rsm_c + 1 : 0;
    resume_well_reset_n <= standby_on && rsm_c >= RSM_DLY;
    core_c <= (sleep_state3_n === 1'b1) ? core_c + 1 : 0;
    // Power good falls as soon as the supply is switched off, ahead of its decay.
    core_power_good <= (sleep_state3_n === 1'b1) && core_c >= CORE_DLY;
    clocks_valid <= core_power_good;
  end
endmodule : board_power_model

// [verif/tb_sleep_state_power_sequencer.sv]
// Testbench taking the sequencer through power-up, sleep, soft-off and resume reset.
`timescale 1ns/1ps
module tb_sleep_state_power_sequencer;
  logic ref_clk, rst, standby_on, stop_grant, second_cycle, sleep_request, soft_off_request, wake_event;
  logic rtc_clk, pci_clk, resume_well_reset_n, core_power_good, clocks_valid;
  logic sleep_state3_n, sleep_state5_n, suspend_status_n, pci_bus_reset_n, processor_sleep_n;
  logic stop_clock_n, processor_reset_n, rtc_resume_isolate, resume_main_isolate;
  logic [3:0] strap_value, strap_out, strap_oe;
  int bad_count = 0;
  int checks = 0;
  int rtc_ticks = 0;
  int wake_t = 0;
  wire logic [7:0] obs = {core_power_good, processor_reset_n, stop_clock_n, processor_sleep_n,
                          pci_bus_reset_n, suspend_status_n, sleep_state5_n, sleep_state3_n};

  sleep_state_power_sequencer #(.CORE_POWER_GOOD_RESET_CYCLES(50), .CLOCKS_VALID_CYCLES(20), .STRAP_W(4)) dut_u (
    .ref_clk, .rst, .rtc_clk, .pci_clk, .resume_well_reset_n, .core_power_good, .clocks_valid, .stop_grant,
    .second_cycle, .sleep_request, .soft_off_request, .wake_event, .strap_value, .sleep_state3_n,
    .sleep_state5_n, .suspend_status_n, .pci_bus_reset_n, .processor_sleep_n, .stop_clock_n,
    .processor_reset_n, .strap_out, .strap_oe, .rtc_resume_isolate, .resume_main_isolate);
  board_power_model model_u (.ref_clk, .standby_on, .sleep_state3_n, .rtc_clk, .pci_clk,
    .resume_well_reset_n, .core_power_good, .clocks_valid);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge rtc_clk) rtc_ticks++;

  task summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task chk_vec(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  task chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Every wait is bounded; running out ends the run as a failure.
  task wait_bit(input int idx, input logic v, output int n);
    n = 0;
    while (obs[idx] !== v && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 3000)
    begin
      bad_count++;
      summarize();
    end
  endtask : wait_bit

  task grant(input logic slp, input logic off);
    stop_grant = 1'b1;
    sleep_request = slp;
    soft_off_request = off;
    @(negedge ref_clk);
    stop_grant = 1'b0;
    sleep_request = 1'b0;
    soft_off_request = 1'b0;
  endtask : grant

  task wake;
    repeat (20) @(negedge ref_clk);
    chk_bit(resume_main_isolate, 1'b1);
    wake_t = rtc_ticks;
    wake_event = 1'b1;
    @(negedge ref_clk);
    wake_event = 1'b0;
  endtask : wake

  task bring_up;
    int n;
    wait_bit(7, 1'b1, n);
    repeat (4) @(negedge ref_clk);
    chk_bit(processor_sleep_n, 1'b1);
    wait_bit(3, 1'b1, n);
    chk_rng(n + 5, 45, 55);
    chk_vec(strap_oe, 4'hF);
    chk_vec(strap_out, strap_value);
    wait_bit(5, 1'b1, n);
    chk_rng(n, 3, 17);
    second_cycle = 1'b1;
    @(negedge ref_clk);
    second_cycle = 1'b0;
    wait_bit(6, 1'b1, n);
    chk_rng(n, 0, 10);
    chk_vec(strap_oe, 4'h0);
  endtask : bring_up

  task power_up;
    int n;
    standby_on = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_bit(sleep_state3_n, 1'b0);
    chk_bit(pci_bus_reset_n, 1'b0);
    chk_bit(rtc_resume_isolate, 1'b1);
    wait_bit(0, 1'b1, n);
    chk_bit(sleep_state5_n, 1'b1);
    chk_bit(suspend_status_n, 1'b1);
    bring_up();
  endtask : power_up

  task sleep_s3;
    int n;
    grant(1'b0, 1'b0);
    repeat (40) @(negedge ref_clk);
    chk_bit(processor_sleep_n, 1'b1);
    grant(1'b1, 1'b0);
    wait_bit(4, 1'b0, n);
    chk_rng(n, 0, 32);
    wait_bit(0, 1'b0, n);
    chk_bit(suspend_status_n, 1'b0);
    chk_bit(pci_bus_reset_n, 1'b0);
    wake();
    wait_bit(0, 1'b1, n);
    chk_rng(rtc_ticks - wake_t, 2, 3);
    bring_up();
  endtask : sleep_s3

  task soft_off;
    int n;
    int t0;
    grant(1'b1, 1'b1);
    wait_bit(1, 1'b0, n);
    chk_bit(sleep_state3_n, 1'b0);
    wake();
    wait_bit(1, 1'b1, n);
    t0 = rtc_ticks;
    wait_bit(0, 1'b1, n);
    chk_rng(rtc_ticks - t0, 2, 3);
    bring_up();
  endtask : soft_off

  task resume_drop;
    standby_on = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_bit(sleep_state3_n, 1'b0);
    chk_bit(sleep_state5_n, 1'b0);
    chk_bit(pci_bus_reset_n, 1'b0);
    chk_bit(processor_reset_n, 1'b0);
    power_up();
  endtask : resume_drop

  initial
  begin
    rst = 1'b1;
    standby_on = 1'b0;
    stop_grant = 1'b0;
    second_cycle = 1'b0;
    sleep_request = 1'b0;
    soft_off_request = 1'b0;
    wake_event = 1'b0;
    strap_value = 4'hA;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    power_up();
    sleep_s3();
    soft_off();
    resume_drop();
    summarize();
  end
endmodule : tb_sleep_state_power_sequencer
